// *** design/cpexw_pkg.sv ***
// package of constants for the exception, watch and event counter block
package cpexw_pkg;
	// register numbers on the coprocessor move port
	localparam logic [4:0] REG_RETURN_ADDRESS = 5'h0e;
	localparam logic [4:0] REG_WATCH_LOW = 5'h12;
	localparam logic [4:0] REG_WATCH_HIGH = 5'h13;
	localparam logic [4:0] REG_PAGE_CONTEXT = 5'h14;
	localparam logic [4:0] REG_EVENT_COUNTER = 5'h19;
	// cause codes
	localparam logic [4:0] CAUSE_INTERRUPT = 5'h00;
	localparam logic [4:0] CAUSE_TLB_MODIFIED = 5'h01;
	localparam logic [4:0] CAUSE_TLB_LOAD_MISS = 5'h02;
	localparam logic [4:0] CAUSE_TLB_STORE_MISS = 5'h03;
	localparam logic [4:0] CAUSE_ADDR_ERROR_LOAD = 5'h04;
	localparam logic [4:0] CAUSE_ADDR_ERROR_STORE = 5'h05;
	localparam logic [4:0] CAUSE_FETCH_BUS_ERROR = 5'h06;
	localparam logic [4:0] CAUSE_DATA_BUS_ERROR = 5'h07;
	localparam logic [4:0] CAUSE_SYSCALL = 5'h08;
	localparam logic [4:0] CAUSE_BREAKPOINT = 5'h09;
	localparam logic [4:0] CAUSE_RESERVED_INSTRUCTION = 5'h0a;
	localparam logic [4:0] CAUSE_COP_UNUSABLE = 5'h0b;
	localparam logic [4:0] CAUSE_OVERFLOW = 5'h0c;
	localparam logic [4:0] CAUSE_TRAP = 5'h0d;
	localparam logic [4:0] CAUSE_FLOATING_POINT = 5'h0f;
	localparam logic [4:0] CAUSE_WATCH = 5'h17;
	// exception kinds reported by the pipeline, one bit each
	localparam int EXC_KINDS = 16;
	localparam int K_INT = 0;
	localparam int K_MOD = 1;
	localparam int K_TLB_LOAD_MISS_CAUSE = 2;
	localparam int K_TLB_STORE_MISS_CAUSE = 3;
	localparam int K_ADDR_ERROR_LOAD_CAUSE = 4;
	localparam int K_ADDR_ERROR_STORE_CAUSE = 5;
	localparam int K_IBE = 6;
	localparam int K_DBE = 7;
	localparam int K_SYS = 8;
	localparam int K_BP = 9;
	localparam int K_RI = 10;
	localparam int K_CPU = 11;
	localparam int K_OV = 12;
	localparam int K_TR = 13;
	localparam int K_FPE = 14;
	localparam int K_WATCH = 15;
	// return address sign field
	localparam int RA_EXT_LO = 40;
	localparam int RA_EXT_HI = 58;
	// extended page context fields
	localparam int CTX_PAGE_LO = 4;
	localparam int CTX_PAGE_W = 27;
	localparam int CTX_REGION_LO = 31;
	localparam int CTX_BASE_LO = 33;
	localparam int CTX_BASE_W = 31;
	localparam int VA_PAGE_LO = 13;
	localparam int VA_REGION_LO = 62;
	// watch registers
	localparam int WATCH_WRITE_BIT = 0;
	localparam int WATCH_READ_BIT = 1;
	localparam int WATCH_ADDR_LO = 3;
	localparam logic [31:0] WATCH_LOW_MASK = 32'hffff_fffb;
	localparam logic [31:0] WATCH_HIGH_MASK = 32'h0000_000f;
	// counter control fields
	localparam int CTL_EXL_BIT = 0;
	localparam int CTL_K_BIT = 1;
	localparam int CTL_S_BIT = 2;
	localparam int CTL_U_BIT = 3;
	localparam int CTL_IE_BIT = 4;
	localparam int CTL_EVENT_LO = 5;
	localparam int CTL_EVENT_W = 4;
	localparam int CTL_IP_BIT = 15;
	localparam logic [31:0] CTL_MASK = 32'h0000_81ff;
	localparam int EVENT_KINDS = 10;
	// mode codes and kernel segment prefix for 64-bit addresses
	localparam logic [1:0] KSU_USER = 2'h2;
	localparam logic [1:0] KSU_SUPER = 2'h1;
	localparam logic [1:0] REGION_KERNEL = 2'h3;
endpackage

// *** design/cpexw_unit.sv ***
// exception recording, watch compare and event counters
//
// Function
// - codes 0-7: interrupt, TLB, address, bus errors
// - codes 8-13,15,23; others reserved
// - return address takes faulting instruction address
// - delay slot: branch address and flag set
// - no return address update while exception level
// - bits 40-58 sign or segment extension
// - page pair field gets address bits 39:13
// - region field gets address bits 63:62
// - page table base readable and writable
// - watch compares physical address bits 35:3
// - read and write enables gate watch
// - reserved watch and control bits read zero
// - two 32-bit counters, one event each
// - overflow with enable sets pending, line seven
// - counting continues after overflow
// - per-counter mode enables
// - events 0-4 cycles, instructions, loads, stores, branches
// - events 5-9 float, flushes, refills, cache misses
// - move instructions select counter or control
// - line seven from timer or counter overflow
// - set exception level on general exceptions
// - delay flag 1 when adjusted else 0
`timescale 1ns/1ps
module cpexw_unit #(
	parameter int COUNTERS = 2
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic exc_commit,
	input wire logic [cpexw_pkg::EXC_KINDS-1:0] exc_kind,
	input wire logic [63:0] exc_pc,
	input wire logic exc_in_delay_slot,
	input wire logic [63:0] exc_bad_vaddr,
	input wire logic mode_64,
	input wire logic exception_level,
	input wire logic error_level,
	input wire logic [1:0] ksu,
	input wire logic mem_valid,
	input wire logic mem_write,
	input wire logic [35:0] watch_physical_address,
	input wire logic [cpexw_pkg::EVENT_KINDS-1:0] event_pulse,
	input wire logic timer_match,
	input wire logic cp_write,
	input wire logic [4:0] cp_reg,
	input wire logic cp_ctl_select,
	input wire logic cp_index,
	input wire logic [63:0] cp_wdata,
	output logic [63:0] cp_rdata,
	output logic [4:0] cause_code,
	output logic delay_slot_flag,
	output logic set_exception_level,
	output logic watch_hit,
	output logic pending_line_seven
);
	// ==========================================================
	// state
	logic [63:0] exception_return_address, next_exception_return_address;
	logic [4:0] next_cause_code;
	logic next_delay_slot_flag;
	logic [cpexw_pkg::CTX_PAGE_W-1:0] faulting_page_pair, next_faulting_page_pair;
	logic [1:0] region, next_region;
	logic [cpexw_pkg::CTX_BASE_W-1:0] page_table_base, next_page_table_base;
	logic [31:0] watch_address_low, next_watch_address_low;
	logic [31:0] watch_address_high, next_watch_address_high;
	logic [31:0] event_counter [COUNTERS];
	logic [31:0] next_event_counter [COUNTERS];
	logic [31:0] event_counter_control [COUNTERS];
	logic [31:0] next_event_counter_control [COUNTERS];
	logic [63:0] next_cp_rdata;
	logic next_set_exception_level, next_watch_hit, next_pending_line_seven;
	logic half_toggle [COUNTERS];
	logic next_half_toggle [COUNTERS];

	// ==========================================================
	// helpers
	// a move reaches counter i when both the register number and the index match
	function automatic logic counter_move(input logic [4:0] r, input logic x, input int i);
		return r == cpexw_pkg::REG_EVENT_COUNTER && 32'(x) == i;
	endfunction

	// with two kind bits up, the lowest one above interrupt wins
	function automatic logic [4:0] encode_cause(input logic [cpexw_pkg::EXC_KINDS-1:0] k);
		logic [4:0] c;
		c = cpexw_pkg::CAUSE_INTERRUPT;
		if (k[cpexw_pkg::K_MOD]) c = cpexw_pkg::CAUSE_TLB_MODIFIED;
		else if (k[cpexw_pkg::K_TLB_LOAD_MISS_CAUSE]) c = cpexw_pkg::CAUSE_TLB_LOAD_MISS;
		else if (k[cpexw_pkg::K_TLB_STORE_MISS_CAUSE]) c = cpexw_pkg::CAUSE_TLB_STORE_MISS;
		else if (k[cpexw_pkg::K_ADDR_ERROR_LOAD_CAUSE]) c = cpexw_pkg::CAUSE_ADDR_ERROR_LOAD;
		else if (k[cpexw_pkg::K_ADDR_ERROR_STORE_CAUSE]) c = cpexw_pkg::CAUSE_ADDR_ERROR_STORE;
		else if (k[cpexw_pkg::K_IBE]) c = cpexw_pkg::CAUSE_FETCH_BUS_ERROR;
		else if (k[cpexw_pkg::K_DBE]) c = cpexw_pkg::CAUSE_DATA_BUS_ERROR;
		else if (k[cpexw_pkg::K_SYS]) c = cpexw_pkg::CAUSE_SYSCALL;
		else if (k[cpexw_pkg::K_BP]) c = cpexw_pkg::CAUSE_BREAKPOINT;
		else if (k[cpexw_pkg::K_RI]) c = cpexw_pkg::CAUSE_RESERVED_INSTRUCTION;
		else if (k[cpexw_pkg::K_CPU]) c = cpexw_pkg::CAUSE_COP_UNUSABLE;
		else if (k[cpexw_pkg::K_OV]) c = cpexw_pkg::CAUSE_OVERFLOW;
		else if (k[cpexw_pkg::K_TR]) c = cpexw_pkg::CAUSE_TRAP;
		else if (k[cpexw_pkg::K_FPE]) c = cpexw_pkg::CAUSE_FLOATING_POINT;
		else if (k[cpexw_pkg::K_WATCH]) c = cpexw_pkg::CAUSE_WATCH;
		return c;
	endfunction

	// bits 40-58 follow bit 31 in 32-bit mode, else the kernel prefix
	function automatic logic [63:0] extend_addr(input logic [63:0] a, input logic m64);
		logic [63:0] r;
		logic fill;
		r = a;
		fill = m64 ? (a[63:62] == cpexw_pkg::REGION_KERNEL) : a[31];
		r[cpexw_pkg::RA_EXT_HI:cpexw_pkg::RA_EXT_LO] = {19{fill}};
		return r;
	endfunction

	// ==========================================================
	// watch compare
	// doubleword granularity: bits 2:0 of the reference never take part
	logic watch_match;
	always_comb begin
		watch_match = mem_valid &&
			watch_physical_address[35:cpexw_pkg::WATCH_ADDR_LO] ==
			{watch_address_high[3:0], watch_address_low[31:cpexw_pkg::WATCH_ADDR_LO]};
	end

	// ==========================================================
	// exception recording and register writes
	logic miss;
	always_comb begin
		next_exception_return_address = exception_return_address;
		next_cause_code = cause_code;
		next_delay_slot_flag = delay_slot_flag;
		next_faulting_page_pair = faulting_page_pair;
		next_region = region;
		next_page_table_base = page_table_base;
		next_watch_address_low = watch_address_low;
		next_watch_address_high = watch_address_high;
		next_set_exception_level = 1'b0;
		next_watch_hit = watch_match && (mem_write ?
			watch_address_low[cpexw_pkg::WATCH_WRITE_BIT] :
			watch_address_low[cpexw_pkg::WATCH_READ_BIT]);
		// only refill misses load the context; other faults leave it alone
		miss = exc_kind[cpexw_pkg::K_TLB_LOAD_MISS_CAUSE] | exc_kind[cpexw_pkg::K_TLB_STORE_MISS_CAUSE];
		if (cp_write) begin
			unique case (cp_reg)
				cpexw_pkg::REG_RETURN_ADDRESS: next_exception_return_address = cp_wdata;
				cpexw_pkg::REG_WATCH_LOW:
					next_watch_address_low = cp_wdata[31:0] & cpexw_pkg::WATCH_LOW_MASK;
				cpexw_pkg::REG_WATCH_HIGH:
					next_watch_address_high = cp_wdata[31:0] & cpexw_pkg::WATCH_HIGH_MASK;
				cpexw_pkg::REG_PAGE_CONTEXT:
					next_page_table_base = cp_wdata[63:cpexw_pkg::CTX_BASE_LO];
				default: ;
			endcase
		end
		// exception commit wins over a return address move in the same cycle unless exception level is raised
		if (exc_commit) begin
			next_cause_code = encode_cause(exc_kind);
			next_set_exception_level = 1'b1;
			// a nested fault keeps the first return address for the handler
			if (!exception_level) begin
				next_exception_return_address = extend_addr(
					exc_in_delay_slot ? exc_pc - 64'h0000_0000_0000_0004 : exc_pc,
					mode_64);
				next_delay_slot_flag = exc_in_delay_slot;
			end
			if (miss) begin
				next_faulting_page_pair = exc_bad_vaddr[39:cpexw_pkg::VA_PAGE_LO];
				next_region = exc_bad_vaddr[63:cpexw_pkg::VA_REGION_LO];
			end
		end
	end

	// ==========================================================
	// event counters
	logic mode_ok [COUNTERS];
	always_comb begin
		logic ev;
		logic [3:0] sel;
		logic [31:0] ctl;
		logic wrap;
		ev = 1'b0;
		wrap = 1'b0;
		sel = 4'h0;
		ctl = 32'h0000_0000;
		next_pending_line_seven = timer_match;
		for (int i = 0; i < COUNTERS; i++) begin
			next_event_counter[i] = event_counter[i];
			next_event_counter_control[i] = event_counter_control[i];
			next_half_toggle[i] = half_toggle[i];
			ctl = event_counter_control[i];
			sel = ctl[cpexw_pkg::CTL_EVENT_LO +: cpexw_pkg::CTL_EVENT_W];
			// error level masks every mode enable
			mode_ok[i] = error_level ? 1'b0 :
				exception_level ? ctl[cpexw_pkg::CTL_EXL_BIT] :
				ksu == cpexw_pkg::KSU_USER ? ctl[cpexw_pkg::CTL_U_BIT] :
				ksu == cpexw_pkg::KSU_SUPER ? ctl[cpexw_pkg::CTL_S_BIT] :
				ctl[cpexw_pkg::CTL_K_BIT];
			ev = (32'(sel) < cpexw_pkg::EVENT_KINDS) ? event_pulse[sel] : 1'b0;
			// instruction and float events count every second occurrence
			if (ev && (sel == 4'h1 || sel == 4'h5)) begin
				next_half_toggle[i] = ~half_toggle[i];
				ev = half_toggle[i];
			end
			wrap = ev && mode_ok[i] && event_counter[i] == 32'hffff_ffff;
			if (ev && mode_ok[i]) begin
				next_event_counter[i] = event_counter[i] + 32'h0000_0001;
				if (wrap && ctl[cpexw_pkg::CTL_IE_BIT])
					next_event_counter_control[i][cpexw_pkg::CTL_IP_BIT] = 1'b1;
			end
			if (cp_write && counter_move(cp_reg, cp_index, i)) begin
				if (cp_ctl_select) begin
					next_event_counter_control[i] = cp_wdata[31:0] & cpexw_pkg::CTL_MASK;
					// a new overflow in this cycle keeps its pending bit
					if (wrap && ctl[cpexw_pkg::CTL_IE_BIT])
						next_event_counter_control[i][cpexw_pkg::CTL_IP_BIT] = 1'b1;
				end else begin
					next_event_counter[i] = cp_wdata[31:0];
				end
			end
			// taken from the next control value so line seven rises with the wrap
			if (next_event_counter_control[i][cpexw_pkg::CTL_IP_BIT])
				next_pending_line_seven = 1'b1;
		end
	end

	// ==========================================================
	// read data
	always_comb begin
		next_cp_rdata = 64'h0000_0000_0000_0000;
		// unmapped register numbers read as zero
		unique case (cp_reg)
			cpexw_pkg::REG_RETURN_ADDRESS: next_cp_rdata = exception_return_address;
			cpexw_pkg::REG_WATCH_LOW: next_cp_rdata = {32'h0000_0000, watch_address_low};
			cpexw_pkg::REG_WATCH_HIGH: next_cp_rdata = {32'h0000_0000, watch_address_high};
			cpexw_pkg::REG_PAGE_CONTEXT:
				next_cp_rdata = {page_table_base, region, faulting_page_pair, 4'h0};
			cpexw_pkg::REG_EVENT_COUNTER:
				next_cp_rdata = {32'h0000_0000, cp_ctl_select ?
					event_counter_control[cp_index] : event_counter[cp_index]};
			default: ;
		endcase
	end

	// ==========================================================
	// exception and watch registers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			exception_return_address <= 64'h0000_0000_0000_0000;
			cause_code <= 5'h00;
			delay_slot_flag <= 1'b0;
			faulting_page_pair <= '0;
			region <= 2'h0;
			page_table_base <= '0;
			watch_address_low <= 32'h0000_0000;
			watch_address_high <= 32'h0000_0000;
			set_exception_level <= 1'b0;
			watch_hit <= 1'b0;
		end else begin
			exception_return_address <= next_exception_return_address;
			cause_code <= next_cause_code;
			delay_slot_flag <= next_delay_slot_flag;
			faulting_page_pair <= next_faulting_page_pair;
			region <= next_region;
			page_table_base <= next_page_table_base;
			watch_address_low <= next_watch_address_low;
			watch_address_high <= next_watch_address_high;
			set_exception_level <= next_set_exception_level;
			watch_hit <= next_watch_hit;
		end
	end

	// ==========================================================
	// counter registers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pending_line_seven <= 1'b0;
			for (int i = 0; i < COUNTERS; i++) begin
				event_counter[i] <= 32'h0000_0000;
				event_counter_control[i] <= 32'h0000_0000;
				half_toggle[i] <= 1'b0;
			end
		end else begin
			pending_line_seven <= next_pending_line_seven;
			for (int i = 0; i < COUNTERS; i++) begin
				event_counter[i] <= next_event_counter[i];
				event_counter_control[i] <= next_event_counter_control[i];
				half_toggle[i] <= next_half_toggle[i];
			end
		end
	end

	// ==========================================================
	// read data register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cp_rdata <= 64'h0000_0000_0000_0000;
		end else begin
			cp_rdata <= next_cp_rdata;
		end
	end
endmodule

// *** dv/cpexw_assertions.sv ***
// port-level checks for the exception, watch and event counter block
`timescale 1ns/1ps
module cpexw_checker (
	input wire logic clk,
	input wire logic resetn,
	input wire logic exc_commit,
	input wire logic [15:0] exc_kind,
	input wire logic exc_in_delay_slot,
	input wire logic exception_level,
	input wire logic mem_valid,
	input wire logic timer_match,
	input wire logic [4:0] cp_reg,
	input wire logic [63:0] cp_rdata,
	input wire logic [4:0] cause_code,
	input wire logic delay_slot_flag,
	input wire logic set_exception_level,
	input wire logic watch_hit,
	input wire logic pending_line_seven
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// ==========
	// exception recording
	a_level_pulse: assert property (exc_commit |=> set_exception_level)
		else $error("status level not raised after commit");
	a_level_quiet: assert property (!exc_commit |=> !set_exception_level)
		else $error("status level raised without commit");
	a_tlb_code: assert property (exc_commit && exc_kind == 16'h0004 |=> cause_code == 5'h02)
		else $error("load miss code wrong");
	a_watch_code: assert property (exc_commit && exc_kind == 16'h8000 |=> cause_code == 5'h17)
		else $error("watch code wrong");
	a_code_hold: assert property (!exc_commit |=> $stable(cause_code))
		else $error("cause code moved without commit");
	a_flag_follow: assert property (exc_commit && !exception_level
		|=> delay_slot_flag == $past(exc_in_delay_slot))
		else $error("delay flag wrong");
	a_flag_kept: assert property (exc_commit && exception_level |=> $stable(delay_slot_flag))
		else $error("delay flag changed at raised level");
	// ==========
	// watch, line seven, decode
	a_hit_cause: assert property (watch_hit |-> $past(mem_valid))
		else $error("watch hit without reference");
	a_timer_line: assert property (timer_match |=> pending_line_seven)
		else $error("line seven low on timer match");
	a_unmapped_zero: assert property (cp_reg == 5'h01 |=> cp_rdata == 64'h0000_0000_0000_0000)
		else $error("unmapped register not zero");
	c_delay: cover property (exc_commit && exc_in_delay_slot);
	c_hit: cover property (watch_hit);
	c_overflow: cover property (pending_line_seven && !timer_match);
endmodule
bind cpexw_unit cpexw_checker cpexw_checker_i (.clk(clk), .resetn(resetn),
	.exc_commit(exc_commit), .exc_kind(exc_kind), .exc_in_delay_slot(exc_in_delay_slot),
	.exception_level(exception_level), .mem_valid(mem_valid), .timer_match(timer_match),
	.cp_reg(cp_reg), .cp_rdata(cp_rdata), .cause_code(cause_code),
	.delay_slot_flag(delay_slot_flag), .set_exception_level(set_exception_level),
	.watch_hit(watch_hit), .pending_line_seven(pending_line_seven));

// *** dv/cpexw_pipe_model.sv ***
// pipeline stand-in: commits exceptions, issues references, reports events
`timescale 1ns/1ps
module cpexw_pipe_model (
	input wire logic clk,
	output logic exc_commit = 1'b0,
	output logic [15:0] exc_kind = 16'h0000,
	output logic [63:0] exc_pc = 64'h0000_0000_0000_0000,
	output logic exc_in_delay_slot = 1'b0,
	output logic [63:0] exc_bad_vaddr = 64'h0000_0000_0000_0000,
	output logic mem_valid = 1'b0,
	output logic mem_write = 1'b0,
	output logic [35:0] watch_physical_address = 36'h0_0000_0000,
	output logic [9:0] event_pulse = 10'h000
);
	// released data lines flip so a stale value never looks current
	task automatic take_exc(input logic [15:0] k, input logic [63:0] pc, va, input logic ds);
		@(posedge clk);
		exc_commit <= 1'b1;
		exc_kind <= k;
		exc_pc <= pc;
		exc_bad_vaddr <= va;
		exc_in_delay_slot <= ds;
		@(posedge clk);
		exc_commit <= 1'b0;
		exc_kind <= 16'h0000;
		exc_pc <= ~pc;
		exc_bad_vaddr <= ~va;
		exc_in_delay_slot <= ~ds;
	endtask
	task automatic mem_ref(input logic wr, input logic [35:0] pa);
		@(posedge clk);
		mem_valid <= 1'b1;
		mem_write <= wr;
		watch_physical_address <= pa;
		@(posedge clk);
		mem_valid <= 1'b0;
		watch_physical_address <= ~pa;
	endtask
	task automatic events(input logic [9:0] m);
		@(posedge clk);
		event_pulse <= m;
		@(posedge clk);
		event_pulse <= 10'h000;
	endtask
endmodule

// *** dv/tb_cp0_exception_watch_perfcount.sv ***
// self-checking bench for the exception, watch and event counter block
`timescale 1ns/1ps
module tb_cp0_exception_watch_perfcount;
	logic clk = 1'b0, resetn = 1'b0, mode_64 = 1'b0, exception_level = 1'b0;
	logic timer_match = 1'b0, cp_write = 1'b0, cp_ctl_select = 1'b0, cp_index = 1'b0;
	logic error_level = 1'b0;
	logic [1:0] ksu = 2'h0;
	logic [4:0] cp_reg = 5'h00;
	logic [63:0] cp_wdata = 64'h0000_0000_0000_0000;
	logic [63:0] cp_rdata, exc_pc, exc_bad_vaddr;
	logic exc_commit, exc_in_delay_slot, mem_valid, mem_write;
	logic [15:0] exc_kind;
	logic [35:0] watch_physical_address;
	logic [9:0] event_pulse;
	logic [4:0] cause_code;
	logic delay_slot_flag, set_exception_level, watch_hit, pending_line_seven;
	int bad_count = 0;
	int n_tests = 0;
	logic [4:0] regs [4] = '{5'h0e, 5'h12, 5'h13, 5'h14};
	logic [63:0] va_miss = 64'h4000_00ab_cdef_1234;
	logic [35:0] pa [5] = '{36'h5_1234_567f, 36'h5_1234_5678, 36'h5_1234_5670,
		36'hd_1234_5678, 36'h5_1234_567c};
	logic [4:0] wrf = 5'b10010;
	logic [4:0] hit = 5'b10001;
	cpexw_pipe_model cpexw_pipe_model_i (.clk(clk), .exc_commit(exc_commit),
		.exc_kind(exc_kind), .exc_pc(exc_pc), .exc_in_delay_slot(exc_in_delay_slot),
		.exc_bad_vaddr(exc_bad_vaddr), .mem_valid(mem_valid), .mem_write(mem_write),
		.watch_physical_address(watch_physical_address), .event_pulse(event_pulse));
	cpexw_unit #(.COUNTERS(2)) cpexw_unit_i (.clk(clk), .resetn(resetn),
		.exc_commit(exc_commit), .exc_kind(exc_kind), .exc_pc(exc_pc),
		.exc_in_delay_slot(exc_in_delay_slot), .exc_bad_vaddr(exc_bad_vaddr),
		.mode_64(mode_64), .exception_level(exception_level), .error_level(error_level),
		.ksu(ksu), .mem_valid(mem_valid), .mem_write(mem_write),
		.watch_physical_address(watch_physical_address), .event_pulse(event_pulse),
		.timer_match(timer_match), .cp_write(cp_write), .cp_reg(cp_reg),
		.cp_ctl_select(cp_ctl_select), .cp_index(cp_index), .cp_wdata(cp_wdata),
		.cp_rdata(cp_rdata), .cause_code(cause_code), .delay_slot_flag(delay_slot_flag),
		.set_exception_level(set_exception_level), .watch_hit(watch_hit),
		.pending_line_seven(pending_line_seven));
	// ==========
	// tasks
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] r, input logic s, x, input logic [63:0] d);
		@(posedge clk);
		cp_write <= 1'b1;
		cp_reg <= r;
		cp_ctl_select <= s;
		cp_index <= x;
		cp_wdata <= d;
		@(posedge clk);
		cp_write <= 1'b0;
		cp_wdata <= ~d;
	endtask
	// read data is registered, so it is sampled one edge after the select
	task automatic rd(input logic [4:0] r, input logic s, x, input logic [63:0] e);
		@(posedge clk);
		cp_reg <= r;
		cp_ctl_select <= s;
		cp_index <= x;
		@(posedge clk);
		#1 chk(cp_rdata, e);
	endtask
	// ==========
	// sequence
	initial forever #10 clk = ~clk;
	initial begin
		#1_000_000;
		bad_count++;
		stop_test;
	end
	initial begin
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		foreach (regs[i]) rd(regs[i], 1'b0, 1'b0, 64'h0);
		for (int i = 0; i < 4; i++) rd(5'h19, i[1], i[0], 64'h0);
		wr(5'h01, 1'b0, 1'b0, 64'h0000_0000_ffff_ffff);
		rd(5'h01, 1'b0, 1'b0, 64'h0);
		for (int k = 0; k < 16; k++) begin
			cpexw_pipe_model_i.take_exc(16'h0001 << k, 64'hffff_ffff_8000_1000, 64'h0, 1'b0);
			#1 chk(cause_code, k < 14 ? k : (k == 14 ? 15 : 23));
			chk(set_exception_level, 64'h1);
		end
		rd(5'h0e, 1'b0, 1'b0, 64'hffff_ffff_8000_1000);
		chk(delay_slot_flag, 64'h0);
		wr(5'h14, 1'b0, 1'b0, {31'h2aaa_5555, 33'h0_0000_0000});
		cpexw_pipe_model_i.take_exc(16'h0004, 64'h0000_0000_0040_0104, va_miss, 1'b1);
		#1 chk(delay_slot_flag, 64'h1);
		rd(5'h0e, 1'b0, 1'b0, 64'h0000_0000_0040_0100);
		rd(5'h14, 1'b0, 1'b0, {31'h2aaa_5555, va_miss[63:62], va_miss[39:13], 4'h0});
		exception_level <= 1'b1;
		cpexw_pipe_model_i.take_exc(16'h0008, 64'h0000_0000_0000_0500, va_miss, 1'b0);
		exception_level <= 1'b0;
		rd(5'h0e, 1'b0, 1'b0, 64'h0000_0000_0040_0100);
		chk(delay_slot_flag, 64'h1);
		mode_64 <= 1'b1;
		cpexw_pipe_model_i.take_exc(16'h1000, 64'hc000_0000_0000_2000, 64'hc000_0000_0000_2000, 1'b0);
		rd(5'h0e, 1'b0, 1'b0, 64'hc7ff_ff00_0000_2000);
		cpexw_pipe_model_i.take_exc(16'h1000, 64'h0000_ff00_0000_3000, 64'h0000_ff00_0000_3000, 1'b0);
		rd(5'h0e, 1'b0, 1'b0, 64'h0000_0000_0000_3000);
		mode_64 <= 1'b0;
		wr(5'h12, 1'b0, 1'b0, 64'h0000_0000_1234_567e);
		wr(5'h13, 1'b0, 1'b0, 64'h0000_0000_ffff_fff5);
		rd(5'h12, 1'b0, 1'b0, 64'h0000_0000_1234_567a);
		rd(5'h13, 1'b0, 1'b0, 64'h0000_0000_0000_0005);
		for (int i = 0; i < 5; i++) begin
			if (i == 4) wr(5'h12, 1'b0, 1'b0, 64'h0000_0000_1234_5679);
			cpexw_pipe_model_i.mem_ref(wrf[i], pa[i]);
			#1 chk(watch_hit, hit[i]);
		end
		for (int ev = 0; ev < 10; ev++) begin
			wr(5'h19, 1'b1, 1'b1, 64'(ev << 5 | 2));
			wr(5'h19, 1'b0, 1'b1, 64'h0);
			cpexw_pipe_model_i.events(10'h3ff ^ (10'h001 << ev));
			repeat (2) cpexw_pipe_model_i.events(10'h001 << ev);
			rd(5'h19, 1'b0, 1'b1, (ev == 1 || ev == 5) ? 1 : 2);
		end
		// user-only counter must ignore kernel-mode events
		wr(5'h19, 1'b1, 1'b1, 64'h0000_0000_0000_0068);
		wr(5'h19, 1'b0, 1'b1, 64'h0);
		cpexw_pipe_model_i.events(10'h008);
		ksu <= 2'h2;
		cpexw_pipe_model_i.events(10'h008);
		rd(5'h19, 1'b0, 1'b1, 64'h1);
		// error level stops it, and raised exception level needs its own enable
		error_level <= 1'b1;
		cpexw_pipe_model_i.events(10'h008);
		error_level <= 1'b0;
		exception_level <= 1'b1;
		cpexw_pipe_model_i.events(10'h008);
		exception_level <= 1'b0;
		rd(5'h19, 1'b0, 1'b1, 64'h1);
		ksu <= 2'h0;
		wr(5'h19, 1'b1, 1'b0, 64'h0000_0000_0000_0072);
		wr(5'h19, 1'b0, 1'b0, 64'h0000_0000_ffff_fffe);
		cpexw_pipe_model_i.events(10'h008);
		#1 chk(pending_line_seven, 64'h0);
		repeat (2) cpexw_pipe_model_i.events(10'h008);
		#1 chk(pending_line_seven, 64'h1);
		rd(5'h19, 1'b0, 1'b0, 64'h1);
		rd(5'h19, 1'b1, 1'b0, 64'h0000_0000_0000_8072);
		wr(5'h19, 1'b1, 1'b0, 64'h0000_0000_0000_0072);
		#1 chk(pending_line_seven, 64'h0);
		timer_match <= 1'b1;
		@(posedge clk);
		#1 chk(pending_line_seven, 64'h1);
		timer_match <= 1'b0;
		stop_test;
	end
endmodule
